/* File: inc/icss_defs.vh */
// constants for the interval counter serial slave
`ifndef ICSS_DEFS_VH
`define ICSS_DEFS_VH
// slave address bytes, write and read
`define ICSS_ADDR_WR 8'hA0
`define ICSS_ADDR_RD 8'hA1
// instruction bytes
`define ICSS_DIV_STOP 8'h11
`define ICSS_DIV_RUN 8'h10
`define ICSS_PWD_ON 8'h21
`define ICSS_PWD_OFF 8'h20
`define ICSS_OSC_OUT_ON 8'h31
`define ICSS_OSC_OUT_OFF 8'h30
`define ICSS_FAST_ON 8'h41
`define ICSS_FAST_OFF 8'h40
`define ICSS_SET_CNT 8'h80
// timing: oscillator rate in Hz and tick periods in seconds
`define ICSS_OSC_HZ 32768
`define ICSS_SLOW_S 32
`define ICSS_FAST_S 1
// byte framing
`define ICSS_LAST_BIT 4'h7
`define ICSS_ACK_BIT 4'h8
`define ICSS_SET_BYTES 2'h3
`define ICSS_LAST_IDX 2'h2
`endif

/* File: rtl/icss_top.v */
// two-wire slave with 24-bit interval counter, divider chain and wake-up pulse
`timescale 1ns/10ps
`include "icss_defs.vh"

// Function
// - 24-bit counter wraps all ones to zero and clears at power-on reset.
// - short counter-set transfer updates only bytes received, high byte first.
// - no counter increment while a counter set is in progress.
// - counter stable during any access; a due increment is held and applied after.
// - interrupt pulse every 32 s together with increment; new count readable at once.
// - answer only address bytes A0h write and A1h read.
// - after a foreign address ignore all traffic until next STOP or START.
// - any number of instructions in any order within one write access.
// - data line driven actively; point-to-point link with push-pull master.
// - sample data on clock rise, change driven data on clock fall.
// - data falls with clock high is START, rises is STOP; both detected.
// - bytes are MSB first, eight bits then one acknowledge clock.
// - as receiver drive data low throughout the acknowledge clock.
// - master nacks last read byte; device then leaves data line high.
// - 11h stops and resets dividers, 10h restarts them.
// - 21h powers down with oscillator stopped, 20h re-enables.
// - 31h routes oscillator clock to interrupt pin, 30h restores pulses.
// - 41h selects one-second increments, 40h returns to 32 seconds.
// - 80h is followed by up to three bytes loading bits 23:16, 15:8, 7:0.
// - read returns high, mid, low bytes cyclically while acked, counter frozen.
// - while dividers stopped the counter holds its value.
// - divider chain divides the oscillator clock down to one tick per 32 s.
// - first increment comes 32 s after the dividers restart.
// - in clock-out mode all else runs, but no interrupt pulses on the pin.
// - counter set takes at most three bytes; the next is an instruction.
module icss_top #(
  parameter DIV_W = 20,
  parameter SLOW_CNT = `ICSS_OSC_HZ * `ICSS_SLOW_S,
  parameter FAST_CNT = `ICSS_OSC_HZ * `ICSS_FAST_S
)(
  input wire mclk,
  input wire rst,
  input wire ce,
  input wire scl_in,
  input wire sda_in,
  input wire osc_in,
  output reg sda_out_q,
  output reg sda_oe_q,
  output reg int_n_q,
  output reg [23:0] count_q,
  output reg div_stopped_q,
  output reg pwr_down_q,
  output reg fast_mode_q,
  output reg osc_clock_out_instr_q,
  output reg access_busy_q
);

  // ************************************************************
  // link states
  // ************************************************************
  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_WR = 3'd2;
  localparam ST_RD = 3'd3;
  localparam ST_IGN = 3'd4;

  localparam [DIV_W-1:0] SLOW_TOP = SLOW_CNT[DIV_W-1:0] - 1'b1;
  localparam [DIV_W-1:0] FAST_TOP = FAST_CNT[DIV_W-1:0] - 1'b1;

  // picks counter byte by index: 0 high, 1 mid, 2 low
  function [7:0] cnt_byte;
    input [23:0] cnt;
    input [1:0] idx;
    begin
      case (idx)
        2'h0: cnt_byte = cnt[23:16];
        2'h1: cnt_byte = cnt[15:8];
        default: cnt_byte = cnt[7:0];
      endcase
    end
  endfunction

  reg scl_prev_q;
  reg sda_prev_q;
  reg osc_prev_q;
  reg [2:0] st_q;
  reg [3:0] bit_cnt_q;
  reg [7:0] shift_q;
  reg ack_q;
  reg [1:0] param_q;
  reg [1:0] byte_idx_q;
  reg [DIV_W-1:0] div_q;
  reg pending_q;

  wire scl_rise = scl_in & ~scl_prev_q;
  wire scl_fall = ~scl_in & scl_prev_q;
  wire start_ev = scl_in & scl_prev_q & sda_prev_q & ~sda_in;
  wire stop_ev = scl_in & scl_prev_q & ~sda_prev_q & sda_in;
  // a stopped oscillator gives no edges, so power-down freezes the chain
  wire osc_rise = osc_in & ~osc_prev_q & ~pwr_down_q;
  wire [7:0] rx_byte = {shift_q[6:0], sda_in};
  wire [DIV_W-1:0] div_top = fast_mode_q ? FAST_TOP : SLOW_TOP;
  wire div_tick = osc_rise & ~div_stopped_q & (div_q >= div_top);
  // increments wait while an access runs; only one request is kept
  wire do_inc = (div_tick | pending_q) & ~access_busy_q & ~div_stopped_q;

  // ************************************************************
  // input edge history
  // ************************************************************
  always @(posedge mclk)
  begin
    if (rst)
    begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
      osc_prev_q <= 1'b0;
    end
    else if (ce)
    begin
      scl_prev_q <= scl_in;
      sda_prev_q <= sda_in;
      osc_prev_q <= osc_in;
    end
  end

  // ************************************************************
  // divider chain and pending increment
  // ************************************************************
  always @(posedge mclk)
  begin
    if (rst)
    begin
      div_q <= {DIV_W{1'b0}};
      pending_q <= 1'b0;
    end
    else if (ce)
    begin
      // held at zero while stopped, so a restart gives a full period
      if (div_stopped_q)
        div_q <= {DIV_W{1'b0}};
      else if (osc_rise)
        div_q <= div_tick ? {DIV_W{1'b0}} : div_q + 1'b1;
      if (div_tick & access_busy_q)
        pending_q <= 1'b1;
      else if (do_inc | div_stopped_q)
        pending_q <= 1'b0;
    end
  end

  // ************************************************************
  // interrupt pin
  // ************************************************************
  always @(posedge mclk)
  begin
    if (rst)
      int_n_q <= 1'b1;
    else if (ce)
    begin
      if (osc_clock_out_instr_q)
        int_n_q <= osc_in & ~pwr_down_q;
      else if (do_inc)
        int_n_q <= 1'b0;
      else if (osc_rise)
        int_n_q <= 1'b1;
    end
  end

  // ************************************************************
  // serial slave, instruction decode and counter
  // ************************************************************
  always @(posedge mclk)
  begin
    if (rst)
    begin
      st_q <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      ack_q <= 1'b0;
      param_q <= 2'h0;
      byte_idx_q <= 2'h0;
      sda_out_q <= 1'b1;
      sda_oe_q <= 1'b0;
      access_busy_q <= 1'b0;
      count_q <= 24'h000000;
      div_stopped_q <= 1'b0;
      pwr_down_q <= 1'b0;
      fast_mode_q <= 1'b0;
      osc_clock_out_instr_q <= 1'b0;
    end
    else if (ce)
    begin
      // counter runs only between accesses; wraps naturally
      if (do_inc)
        count_q <= count_q + 24'h000001;
      if (start_ev)
      begin
        st_q <= ST_ADDR;
        bit_cnt_q <= 4'h0;
        ack_q <= 1'b0;
        param_q <= 2'h0;
        sda_oe_q <= 1'b0;
        sda_out_q <= 1'b1;
        access_busy_q <= 1'b0;
      end
      else if (stop_ev)
      begin
        st_q <= ST_IDLE;
        ack_q <= 1'b0;
        param_q <= 2'h0;
        sda_oe_q <= 1'b0;
        sda_out_q <= 1'b1;
        access_busy_q <= 1'b0;
      end
      else if (scl_rise)
      begin
        // sample side of each bit
        case (st_q)
          ST_ADDR:
          begin
            shift_q <= rx_byte;
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (bit_cnt_q == `ICSS_LAST_BIT)
            begin
              if (rx_byte == `ICSS_ADDR_WR)
              begin
                st_q <= ST_WR;
                ack_q <= 1'b1;
                access_busy_q <= 1'b1;
              end
              else if (rx_byte == `ICSS_ADDR_RD)
              begin
                st_q <= ST_RD;
                ack_q <= 1'b1;
                byte_idx_q <= 2'h0;
                access_busy_q <= 1'b1;
              end
              else
                st_q <= ST_IGN;
            end
          end
          ST_WR:
          begin
            if (bit_cnt_q == `ICSS_ACK_BIT)
              bit_cnt_q <= 4'h0;
            else
            begin
              shift_q <= rx_byte;
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
            if (bit_cnt_q == `ICSS_LAST_BIT)
            begin
              ack_q <= 1'b1;
              if (param_q != 2'h0)
              begin
                // each byte lands as soon as it arrives, so a short set
                // leaves the later bytes untouched; it also overrides any
                // increment of the same cycle
                case (param_q)
                  2'h3: count_q[23:16] <= rx_byte;
                  2'h2: count_q[15:8] <= rx_byte;
                  default: count_q[7:0] <= rx_byte;
                endcase
                param_q <= param_q - 2'h1;
              end
              else
              begin
                // each byte after a finished instruction is a new one
                case (rx_byte)
                  `ICSS_DIV_STOP: div_stopped_q <= 1'b1;
                  `ICSS_DIV_RUN: div_stopped_q <= 1'b0;
                  `ICSS_PWD_ON: pwr_down_q <= 1'b1;
                  `ICSS_PWD_OFF: pwr_down_q <= 1'b0;
                  `ICSS_OSC_OUT_ON: osc_clock_out_instr_q <= 1'b1;
                  `ICSS_OSC_OUT_OFF: osc_clock_out_instr_q <= 1'b0;
                  `ICSS_FAST_ON: fast_mode_q <= 1'b1;
                  `ICSS_FAST_OFF: fast_mode_q <= 1'b0;
                  `ICSS_SET_CNT: param_q <= `ICSS_SET_BYTES;
                  default: param_q <= 2'h0;
                endcase
              end
            end
          end
          ST_RD:
          begin
            if (bit_cnt_q == `ICSS_ACK_BIT)
            begin
              bit_cnt_q <= 4'h0;
              if (sda_in)
                st_q <= ST_IGN;
            end
            else
              bit_cnt_q <= bit_cnt_q + 4'h1;
          end
          default:
            bit_cnt_q <= bit_cnt_q;
        endcase
      end
      else if (scl_fall)
      begin
        // drive side of each bit
        if (ack_q && (bit_cnt_q == `ICSS_ACK_BIT))
        begin
          sda_out_q <= 1'b0;
          sda_oe_q <= 1'b1;
        end
        else if (ack_q && (bit_cnt_q == 4'h0) && (st_q == ST_WR))
        begin
          ack_q <= 1'b0;
          sda_out_q <= 1'b1;
          sda_oe_q <= 1'b0;
        end
        else if ((st_q == ST_RD) && (bit_cnt_q == 4'h0))
        begin
          // load next byte in turn, high, mid, low, then again
          ack_q <= 1'b0;
          shift_q <= cnt_byte(count_q, byte_idx_q);
          sda_out_q <= |(cnt_byte(count_q, byte_idx_q) & 8'h80);
          sda_oe_q <= 1'b1;
          byte_idx_q <= (byte_idx_q == `ICSS_LAST_IDX) ? 2'h0 : byte_idx_q + 2'h1;
        end
        else if ((st_q == ST_RD) && (bit_cnt_q == `ICSS_ACK_BIT))
        begin
          sda_out_q <= 1'b1;
          sda_oe_q <= 1'b0;
        end
        else if (st_q == ST_RD)
        begin
          shift_q <= {shift_q[6:0], 1'b0};
          sda_out_q <= shift_q[6];
        end
        else if (st_q == ST_IGN)
        begin
          // after a nack the line is left high for the master's STOP
          sda_out_q <= 1'b1;
          sda_oe_q <= 1'b0;
        end
      end
    end
  end

endmodule

/* File: testbench/icss_asserts.sv */
// assertion checker watching the serial slave top ports
`timescale 1ns/10ps
module icss_asserts (
  input logic mclk,
  input logic rst,
  input logic scl_in,
  input logic sda_in,
  input logic osc_in,
  input logic sda_out_q,
  input logic sda_oe_q,
  input logic int_n_q,
  input logic [23:0] count_q,
  input logic div_stopped_q,
  input logic pwr_down_q,
  input logic osc_clock_out_instr_q,
  input logic access_busy_q
);
  // ****
  // properties
  // ****
  reg [23:0] cnt_p;
  reg busy_p;
  wire quiet;
  // last count and busy; quiet skips the cycle after an access ends, and a pending tick lands one cycle later, so it is checked
  always @(posedge mclk)
  begin
    cnt_p <= count_q;
    busy_p <= access_busy_q;
  end
  assign quiet = !access_busy_q && !busy_p;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_step; quiet && count_q != cnt_p |-> count_q == cnt_p + 24'h000001; endproperty
  property p_pulse; quiet && count_q != cnt_p && !osc_clock_out_instr_q |-> !int_n_q; endproperty
  property p_hold; div_stopped_q && $past(div_stopped_q) && quiet |-> count_q == cnt_p; endproperty
  property p_sleep; pwr_down_q && $past(pwr_down_q) && quiet |-> count_q == cnt_p; endproperty
  property p_osc;
    osc_clock_out_instr_q && $past(osc_clock_out_instr_q) && !pwr_down_q && !$past(pwr_down_q)
      |-> int_n_q == $past(osc_in);
  endproperty
  property p_idle; quiet |-> !sda_oe_q; endproperty
  property p_fall; $changed(sda_out_q) || $changed(sda_oe_q) |-> !$past(scl_in); endproperty
  property p_cond; scl_in && $past(scl_in) && $changed(sda_in) |=> !access_busy_q; endproperty
  a_step: assert property (p_step) else $error("count moved by other than one");
  a_pulse: assert property (p_pulse) else $error("no pulse with increment");
  a_hold: assert property (p_hold) else $error("count moved while stopped");
  a_sleep: assert property (p_sleep) else $error("count moved in power-down");
  a_osc: assert property (p_osc) else $error("pin does not follow oscillator");
  a_idle: assert property (p_idle) else $error("data driven while not addressed");
  a_fall: assert property (p_fall) else $error("data changed after clock high");
  a_cond: assert property (p_cond) else $error("access open after start or stop");
  c_int: cover property ($fell(int_n_q));
  c_busy: cover property ($rose(access_busy_q));
  c_osc: cover property ($rose(osc_clock_out_instr_q));
endmodule
bind icss_top icss_asserts u_chk (.mclk(mclk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in),
  .osc_in(osc_in), .sda_out_q(sda_out_q), .sda_oe_q(sda_oe_q), .int_n_q(int_n_q),
  .count_q(count_q), .div_stopped_q(div_stopped_q), .pwr_down_q(pwr_down_q),
  .osc_clock_out_instr_q(osc_clock_out_instr_q), .access_busy_q(access_busy_q));

/* File: testbench/icss_mst.sv */
// two-wire bus master model, push-pull, driving the serial slave
`timescale 1ns/10ps
module icss_mst (
  input wire mclk,
  output reg scl,
  output reg sda_m,
  output reg oe_m,
  input wire sda_w
);
  // ****
  // bus phases
  // ****
  initial
  begin
    scl = 1'b1;
    sda_m = 1'b1;
    oe_m = 1'b1;
  end
  // one clock phase, three cycles, leaving us just past an edge
  task ph;
  begin
    repeat (3) @(posedge mclk);
    #1;
  end
  endtask
  task start;
  begin
    oe_m = 1'b1;
    sda_m = 1'b1;
    ph;
    sda_m = 1'b0;
    ph;
    scl = 1'b0;
    ph;
  end
  endtask
  task stop;
  begin
    oe_m = 1'b1;
    sda_m = 1'b0;
    ph;
    scl = 1'b1;
    ph;
    sda_m = 1'b1;
    ph;
  end
  endtask
  // eight bits then ack; q holds what the wire showed at each rising clock
  task xb(input [7:0] d, input rd, input k, output [8:0] q);
    integer i;
  begin
    for (i = 8; i >= 0; i = i - 1)
    begin
      @(posedge mclk);
      #1;
      oe_m = (i > 0) ? !rd : rd;
      sda_m = (i > 0) ? d[i-1] : k;
      ph;
      scl = 1'b1;
      ph;
      q = {q[7:0], sda_w};
      scl = 1'b0;
    end
  end
  endtask
endmodule

/* File: testbench/tb_top.sv */
// self-checking bench for the interval counter serial slave
`timescale 1ns/10ps
`include "icss_defs.vh"
`define CHK(n, e, a) begin comparisons = comparisons + 1; if ((a) !== (e)) begin \
  miscompares = miscompares + 1; $display("CHECK FAILED %s expected %0h seen %0h", n, e, a); end end
module tb_top;
  // ****
  // harness and scenarios
  // ****
  reg mclk = 1'b0;
  reg rst = 1'b1;
  reg ce = 1'b1;
  reg osc_in = 1'b0;
  wire scl_in, sda_in, m_sda, m_oe, sda_out_q, sda_oe_q, int_n_q;
  wire div_stopped_q, pwr_down_q, fast_mode_q, osc_clock_out_instr_q, access_busy_q;
  wire [23:0] count_q;
  integer miscompares = 0;
  integer comparisons = 0;
  integer i, n;
  reg [8:0] r;
  reg [7:0] op;
  reg [3:0] e;
  reg [23:0] c;
  // pull-up when nobody drives the data line
  assign sda_in = sda_oe_q ? sda_out_q : (m_oe ? m_sda : 1'b1);
  // short counts: slow tick every 16 oscillator rises, fast every 4
  icss_top #(.SLOW_CNT(16), .FAST_CNT(4)) DUT (.mclk(mclk), .rst(rst), .ce(ce),
    .scl_in(scl_in), .sda_in(sda_in), .osc_in(osc_in), .sda_out_q(sda_out_q),
    .sda_oe_q(sda_oe_q), .int_n_q(int_n_q), .count_q(count_q), .div_stopped_q(div_stopped_q),
    .pwr_down_q(pwr_down_q), .fast_mode_q(fast_mode_q),
    .osc_clock_out_instr_q(osc_clock_out_instr_q), .access_busy_q(access_busy_q));
  icss_mst u_m (.mclk(mclk), .scl(scl_in), .sda_m(m_sda), .oe_m(m_oe), .sda_w(sda_in));
  always #5 mclk = ~mclk;
  // oscillator stand-in, 16 cycles a period
  always
  begin
    repeat (8) @(posedge mclk);
    #1 osc_in = ~osc_in;
  end
  task results;
  begin
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  task wr(input [7:0] d);
  begin
    u_m.xb(d, 1'b0, 1'b0, r);
    `CHK("ack", 1'b0, r[0])
  end
  endtask
  task rd(input [7:0] x, input k);
  begin
    u_m.xb(8'hFF, 1'b1, k, r);
    `CHK("read byte", x, r[8:1])
  end
  endtask
  task t_modes;
  begin
    u_m.start;
    wr(`ICSS_ADDR_WR);
    for (i = 0; i < 8; i = i + 1)
    begin
      op = (i % 4 + 1) * 16 + (i < 4 ? 1 : 0);
      e = (i < 4) ? (4'hF >> (3 - i)) : (4'hF << (i - 3));
      wr(op);
      `CHK("mode flags", e, {fast_mode_q, osc_clock_out_instr_q, pwr_down_q, div_stopped_q})
    end
    u_m.stop;
    $display("t_modes done");
  end
  endtask
  task t_foreign;
  begin
    u_m.start;
    u_m.xb(8'hA2, 1'b0, 1'b0, r);
    `CHK("foreign ack", 1'b1, r[0])
    u_m.xb(`ICSS_DIV_STOP, 1'b0, 1'b0, r);
    `CHK("ignored byte", 1'b0, div_stopped_q)
    `CHK("foreign busy", 1'b0, access_busy_q)
    u_m.stop;
    $display("t_foreign done");
  end
  endtask
  task t_set;
  begin
    u_m.start;
    wr(`ICSS_ADDR_WR);
    wr(`ICSS_DIV_STOP);
    wr(`ICSS_SET_CNT);
    wr(8'h12);
    wr(8'h34);
    wr(8'h56);
    wr(`ICSS_FAST_ON);
    `CHK("count set", 24'h123456, count_q)
    `CHK("fourth byte", 1'b1, fast_mode_q)
    u_m.stop;
    u_m.start;
    wr(`ICSS_ADDR_WR);
    wr(`ICSS_SET_CNT);
    wr(8'h9A);
    u_m.stop;
    `CHK("partial set", 24'h9A3456, count_q)
    $display("t_set done");
  end
  endtask
  task t_read;
  begin
    u_m.start;
    wr(`ICSS_ADDR_RD);
    rd(8'h9A, 1'b0);
    rd(8'h34, 1'b0);
    rd(8'h56, 1'b0);
    rd(8'h9A, 1'b1);
    `CHK("released", 1'b0, sda_oe_q)
    u_m.stop;
    $display("t_read done");
  end
  endtask
  task t_tick;
  begin
    u_m.start;
    wr(`ICSS_ADDR_WR);
    wr(`ICSS_FAST_OFF);
    wr(`ICSS_SET_CNT);
    repeat (3) wr(8'hFF);
    wr(`ICSS_DIV_RUN);
    u_m.stop;
    n = 0;
    while (count_q === 24'hFFFFFF && n < 400)
    begin
      @(posedge mclk);
      #1 n = n + 1;
    end
    `CHK("wrap", 24'h000000, count_q)
    `CHK("pulse", 1'b0, int_n_q)
    `CHK("first tick late", 1'b1, n > 200)
    $display("t_tick done");
  end
  endtask
  task t_hold;
  begin
    // restart the chain at a known point so fast ticks land clear of the checks
    u_m.start;
    wr(`ICSS_ADDR_WR);
    wr(`ICSS_FAST_ON);
    wr(`ICSS_DIV_STOP);
    wr(`ICSS_DIV_RUN);
    u_m.stop;
    u_m.start;
    wr(`ICSS_ADDR_RD);
    c = count_q;
    rd(c[23:16], 1'b0);
    rd(c[15:8], 1'b0);
    rd(c[7:0], 1'b1);
    `CHK("frozen", c, count_q)
    `CHK("busy in read", 1'b1, access_busy_q)
    // the read spans several tick periods, but only one request is held
    u_m.stop;
    repeat (2) @(posedge mclk);
    #1;
    `CHK("pending tick", c + 24'h000001, count_q)
    // with the enable low nothing moves although several ticks fall due
    c = count_q;
    ce = 1'b0;
    repeat (200) @(posedge mclk);
    #1;
    `CHK("enable low", c, count_q)
    ce = 1'b1;
    $display("t_hold done");
  end
  endtask
  // guard against a hung handshake
  initial
  begin
    #200000;
    miscompares = miscompares + 1;
    results;
  end
  initial
  begin
    repeat (8) @(posedge mclk);
    #1 rst = 1'b0;
    `CHK("reset count", 24'h000000, count_q)
    `CHK("reset pin", 1'b1, int_n_q)
    t_modes;
    t_foreign;
    t_set;
    t_read;
    t_tick;
    t_hold;
    results;
  end
endmodule
